/* File: hdl/ctb_host.sv */
// Host controller that loads the timing configuration words into the device
`timescale 1ns/1ps
module ctb_host (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Device register port
  output logic dev_sel_o,
  output logic dev_we_o,
  output logic [7:0] dev_addr_o,
  output logic [31:0] dev_wdata_o,
  input wire logic [31:0] dev_rdata_i,
  input wire logic dev_ready_i,
  // Device cycle phase
  input wire logic nit_active_i
);

  // ****************************************
  // Declarations
  // ****************************************
  logic [ctb_pkg::NUM_CFG-1:0][31:0] cfg_q;
  logic [ctb_pkg::NUM_CHK-1:0] viol;
  logic [ctb_pkg::NUM_CHK-1:0] viol_q;
  ctb_pkg::ctb_state_t st_q;
  logic [2:0] idx_q;
  logic mode_ext_q;
  logic cfg_ok_q;
  logic done_q, ref_state_q, ref_range_q, ref_nit_q;
  logic [ctb_pkg::CODE_W-1:0] code_q;
  logic acc_req, acc_we, acc_done;
  logic [7:0] acc_addr;
  logic [31:0] acc_wdata, acc_rdata;
  logic setup, wr_en, start_all, start_ext, busy;
  logic [2:0] apb_idx;
  logic apb_cfg_hit;

  // APB word index of a configuration register
  function automatic logic [2:0] cfg_index(input logic [7:0] a);
    logic [7:0] off;
    off = a - ctb_pkg::APB_CFG_BASE;
    cfg_index = off[4:2];
  endfunction

  function automatic logic in_cfg_state(input logic [ctb_pkg::CODE_W-1:0] c);
    in_cfg_state = (c == ctb_pkg::CODE_DEFAULT_CONFIG) || (c == ctb_pkg::CODE_CONFIG);
  endfunction

  // ****************************************
  // APB decode
  // ****************************************
  assign setup = psel_i && !penable_i;
  assign busy = (st_q != ctb_pkg::CTB_IDLE);
  assign apb_idx = cfg_index(paddr_i);
  assign apb_cfg_hit = (paddr_i[1:0] == 2'b00) && (paddr_i >= ctb_pkg::APB_CFG_BASE)
    && (paddr_i < ctb_pkg::APB_CTRL);
  assign wr_en = psel_i && penable_i && pwrite_i && pready_o;
  assign start_all = wr_en && (paddr_i == ctb_pkg::APB_CTRL) && pwdata_i[ctb_pkg::CTRL_ALL] && !busy;
  assign start_ext = wr_en && (paddr_i == ctb_pkg::APB_CTRL) && !pwdata_i[ctb_pkg::CTRL_ALL]
    && pwdata_i[ctb_pkg::CTRL_EXT] && !busy;

  // Answer in the access phase; data prepared during setup so outputs are registered
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h00000000;
    end else begin
      pready_o <= setup;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h00000000;
      if (setup) begin
        if (apb_cfg_hit) begin
          prdata_o <= cfg_q[apb_idx];
        end else if (paddr_i == ctb_pkg::APB_CTRL) begin
          prdata_o <= 32'h00000000;
        end else if (paddr_i == ctb_pkg::APB_STATUS) begin
          prdata_o[ctb_pkg::ST_BUSY] <= busy;
          prdata_o[ctb_pkg::ST_DONE] <= done_q;
          prdata_o[ctb_pkg::ST_REF_STATE] <= ref_state_q;
          prdata_o[ctb_pkg::ST_REF_RANGE] <= ref_range_q;
          prdata_o[ctb_pkg::ST_REF_NIT] <= ref_nit_q;
          prdata_o[ctb_pkg::ST_CODE_LSB +: ctb_pkg::CODE_W] <= code_q;
        end else if (paddr_i == ctb_pkg::APB_VIOL) begin
          prdata_o[ctb_pkg::NUM_CHK-1:0] <= viol_q;
        end else begin
          pslverr_o <= 1'b1;
        end
      end
    end
  end

  // Shadow words; frozen while a load runs so the device sees one consistent set
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_q <= '0;
    end else if (wr_en && apb_cfg_hit && !busy) begin
      cfg_q[apb_idx] <= pwdata_i & ctb_pkg::CFG_MASK[apb_idx];
    end
  end

  // ****************************************
  // Field checks
  // ****************************************
  ctb_range_chk u_chk (
    .cfg_i(cfg_q),
    .viol_o(viol)
  );

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      viol_q <= '0;
    end else begin
      viol_q <= viol;
    end
  end

  // ****************************************
  // Load sequencer
  // ****************************************
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_q <= ctb_pkg::CTB_IDLE;
      idx_q <= 3'h0;
      mode_ext_q <= 1'b0;
      cfg_ok_q <= 1'b0;
    end else begin
      unique case (st_q)
        ctb_pkg::CTB_IDLE: begin
          cfg_ok_q <= 1'b0;
          if (start_all) begin
            mode_ext_q <= 1'b0;
            idx_q <= 3'h0;
            st_q <= (|viol) ? ctb_pkg::CTB_END : ctb_pkg::CTB_RD;
          end else if (start_ext) begin
            mode_ext_q <= 1'b1;
            idx_q <= ctb_pkg::EXT_IDX;
            // Control fields carry no state gate, only the idle-time one
            // Word 6 goes out whole so the device combines value and mode as one set
            st_q <= nit_active_i ? ctb_pkg::CTB_END : ctb_pkg::CTB_WR;
          end
        end
        ctb_pkg::CTB_RD: begin
          st_q <= ctb_pkg::CTB_RD_W;
        end
        ctb_pkg::CTB_RD_W: begin
          if (acc_done) begin
            cfg_ok_q <= in_cfg_state(acc_rdata[ctb_pkg::CODE_W-1:0]);
            st_q <= in_cfg_state(acc_rdata[ctb_pkg::CODE_W-1:0]) ? ctb_pkg::CTB_WR : ctb_pkg::CTB_END;
          end
        end
        ctb_pkg::CTB_WR: begin
          st_q <= ctb_pkg::CTB_WR_W;
        end
        ctb_pkg::CTB_WR_W: begin
          if (acc_done) begin
            if (mode_ext_q || idx_q == ctb_pkg::LAST_IDX) begin
              st_q <= ctb_pkg::CTB_END;
            end else begin
              idx_q <= idx_q + 3'h1;
              st_q <= ctb_pkg::CTB_WR;
            end
          end
        end
        ctb_pkg::CTB_END: begin
          st_q <= ctb_pkg::CTB_IDLE;
        end
        default: begin
          st_q <= ctb_pkg::CTB_IDLE;
        end
      endcase
    end
  end

  // Outcome flags: cleared by a new command, which cannot start while one runs
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      done_q <= 1'b0;
      ref_state_q <= 1'b0;
      ref_range_q <= 1'b0;
      ref_nit_q <= 1'b0;
      code_q <= '0;
    end else if (start_all || start_ext) begin
      done_q <= 1'b0;
      ref_state_q <= 1'b0;
      ref_range_q <= start_all && (|viol);
      ref_nit_q <= start_ext && nit_active_i;
    end else begin
      if (st_q == ctb_pkg::CTB_RD_W && acc_done) begin
        code_q <= acc_rdata[ctb_pkg::CODE_W-1:0];
        ref_state_q <= !in_cfg_state(acc_rdata[ctb_pkg::CODE_W-1:0]);
      end
      if (st_q == ctb_pkg::CTB_END) begin
        done_q <= 1'b1;
      end
    end
  end

  // ****************************************
  // Device access
  // ****************************************
  assign acc_req = (st_q == ctb_pkg::CTB_RD) || (st_q == ctb_pkg::CTB_WR);
  assign acc_we = (st_q == ctb_pkg::CTB_WR);
  assign acc_addr = (st_q == ctb_pkg::CTB_RD) ? ctb_pkg::DEV_STATUS
    : ctb_pkg::DEV_CFG_BASE + {3'h0, idx_q, 2'b00};
  assign acc_wdata = cfg_q[idx_q];

  ctb_dev_access u_acc (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .req_i(acc_req),
    .we_i(acc_we),
    .addr_i(acc_addr),
    .wdata_i(acc_wdata),
    .done_o(acc_done),
    .rdata_o(acc_rdata),
    .dev_sel_o(dev_sel_o),
    .dev_we_o(dev_we_o),
    .dev_addr_o(dev_addr_o),
    .dev_wdata_o(dev_wdata_o),
    .dev_rdata_i(dev_rdata_i),
    .dev_ready_i(dev_ready_i)
  );

  // ****************************************
  // Checks
  // ****************************************
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  sequence bad_state_read;
    st_q == ctb_pkg::CTB_RD_W && acc_done && !in_cfg_state(acc_rdata[ctb_pkg::CODE_W-1:0]);
  endsequence

  sequence load_abandoned;
    st_q == ctb_pkg::CTB_END ##1 st_q == ctb_pkg::CTB_IDLE && !dev_sel_o;
  endsequence

  state_refuse_a: assert property (bad_state_read |=> load_abandoned)
    else $error("load continued outside a configuration state");
  cfg_write_gate_a: assert property (dev_sel_o && dev_we_o && !mode_ext_q |-> cfg_ok_q)
    else $error("configuration write without configuration state");
  range_refuse_a: assert property (start_all && (|viol) |=> st_q == ctb_pkg::CTB_END && ref_range_q ##1 done_q)
    else $error("out of range set was sent");
  nit_refuse_a: assert property (start_ext && nit_active_i |=> st_q == ctb_pkg::CTB_END && ref_nit_q ##1 ref_nit_q)
    else $error("control update during idle time");
  ext_word_only_a: assert property (st_q == ctb_pkg::CTB_WR && mode_ext_q |-> idx_q == ctb_pkg::EXT_IDX)
    else $error("control update touched another word");
  reserved_zero_a: assert property (pready_o && apb_cfg_hit
    |-> (prdata_o & ~ctb_pkg::CFG_MASK[apb_idx]) == 32'h00000000)
    else $error("unassigned bits read nonzero");
  apb_answer_a: assert property (setup |=> pready_o ##1 !pready_o)
    else $error("APB answer not one cycle after setup");

endmodule // ctb_host

/* File: hdl/ctb_pkg.sv */
// Constants, register map and types of the timing configuration host controller
package ctb_pkg;

  // ****************************************
  // APB map of the controller
  // ****************************************
  localparam int unsigned NUM_CFG = 7;
  localparam logic [7:0] APB_CFG_BASE = 8'h00;
  localparam logic [7:0] APB_CTRL = 8'h1c;
  localparam logic [7:0] APB_STATUS = 8'h20;
  localparam logic [7:0] APB_VIOL = 8'h24;
  localparam logic [7:0] APB_STEP = 8'h04;
  localparam logic [2:0] EXT_IDX = 3'h6;
  localparam logic [2:0] LAST_IDX = 3'h6;

  // Control and status bits
  localparam int unsigned CTRL_ALL = 0;
  localparam int unsigned CTRL_EXT = 1;
  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_DONE = 1;
  localparam int unsigned ST_REF_STATE = 2;
  localparam int unsigned ST_REF_RANGE = 3;
  localparam int unsigned ST_REF_NIT = 4;
  localparam int unsigned ST_CODE_LSB = 8;

  // ****************************************
  // Device side map
  // ****************************************
  localparam logic [7:0] DEV_CFG_BASE = 8'h00;
  localparam logic [7:0] DEV_STATUS = 8'h40;
  localparam int unsigned CODE_W = 6;
  localparam logic [5:0] CODE_DEFAULT_CONFIG = 6'h00;
  localparam logic [5:0] CODE_CONFIG = 6'h0f;

  // Writable bits of each configuration word, all others read zero
  localparam logic [NUM_CFG-1:0][31:0] CFG_MASK = {
    32'h07070303, 32'h07ff3fff, 32'h00031f3f, 32'h1fff003f,
    32'h03ff03ff, 32'h07ff07ff, 32'hff1fffff};

  // ****************************************
  // Field positions, widths and limits
  // ****************************************
  localparam int unsigned DEC_LSB = 24, DEC_W = 8, DEC_LO = 14, DEC_HI = 143;
  localparam int unsigned CDD_LSB = 16, CDD_W = 5, CDD_LO = 0, CDD_HI = 20;
  localparam int unsigned DCB_LSB = 8, DCA_LSB = 0, DC_W = 8, DC_LO = 0, DC_HI = 200;
  localparam int unsigned MOD_LSB = 16, MOD_W = 11, MOD_LO = 2, MOD_HI = 1923;
  localparam int unsigned ASR_LSB = 0, ASR_W = 11, ASR_LO = 0, ASR_HI = 1875;
  localparam int unsigned NSS_LSB = 16, NSS_W = 10, NSS_LO = 2, NSS_HI = 1023;
  localparam int unsigned SSL_LSB = 0, SSL_W = 10, SSL_LO = 4, SSL_HI = 659;
  localparam int unsigned NMS_LSB = 16, NMS_W = 13, NMS_LO = 0, NMS_HI = 7986;
  localparam int unsigned MSL_LSB = 0, MSL_W = 6, MSL_LO = 2, MSL_HI = 63;
  localparam int unsigned DSI_LSB = 16, DSI_W = 2, DSI_LO = 0, DSI_HI = 2;
  localparam int unsigned MAPO_LSB = 8, MAPO_W = 5, MAPO_LO = 1, MAPO_HI = 31;
  localparam int unsigned APO_LSB = 0, APO_W = 6, APO_LO = 1, APO_HI = 63;
  localparam int unsigned MRC_LSB = 16, MRC_W = 11, MRC_LO = 2, MRC_HI = 1923;
  localparam int unsigned MOC_LSB = 0, MOC_W = 14, MOC_LO = 5, MOC_HI = 15266;
  localparam int unsigned NUM_CHK = 15;

  // External correction control codes
  typedef enum logic [1:0] {
    CTB_EXT_NONE0 = 2'b00,
    CTB_EXT_NONE1 = 2'b01,
    CTB_EXT_SUB = 2'b10,
    CTB_EXT_ADD = 2'b11
  } ctb_ext_ctrl_t;

  typedef enum logic [2:0] {
    CTB_IDLE = 3'b000,
    CTB_RD = 3'b001,
    CTB_RD_W = 3'b010,
    CTB_WR = 3'b011,
    CTB_WR_W = 3'b100,
    CTB_END = 3'b101
  } ctb_state_t;

endpackage

/* File: hdl/ctb_range_chk.sv */
// Range checker of the configuration words held by the controller
`timescale 1ns/1ps
module ctb_range_chk (
  // Configuration words
  input wire logic [ctb_pkg::NUM_CFG-1:0][31:0] cfg_i,
  // One bit per out-of-range field
  output logic [ctb_pkg::NUM_CHK-1:0] viol_o
);

  function automatic logic bad(input logic [15:0] v, input int unsigned lo, input int unsigned hi);
    bad = (v < 16'(lo)) || (v > 16'(hi));
  endfunction

  always_comb begin
    viol_o[0] = bad(16'(cfg_i[0][ctb_pkg::DEC_LSB +: ctb_pkg::DEC_W]), ctb_pkg::DEC_LO, ctb_pkg::DEC_HI);
    viol_o[1] = bad(16'(cfg_i[0][ctb_pkg::CDD_LSB +: ctb_pkg::CDD_W]), ctb_pkg::CDD_LO, ctb_pkg::CDD_HI);
    viol_o[2] = bad(16'(cfg_i[0][ctb_pkg::DCB_LSB +: ctb_pkg::DC_W]), ctb_pkg::DC_LO, ctb_pkg::DC_HI);
    viol_o[3] = bad(16'(cfg_i[0][ctb_pkg::DCA_LSB +: ctb_pkg::DC_W]), ctb_pkg::DC_LO, ctb_pkg::DC_HI);
    viol_o[4] = bad(16'(cfg_i[1][ctb_pkg::MOD_LSB +: ctb_pkg::MOD_W]), ctb_pkg::MOD_LO, ctb_pkg::MOD_HI);
    viol_o[5] = bad(16'(cfg_i[1][ctb_pkg::ASR_LSB +: ctb_pkg::ASR_W]), ctb_pkg::ASR_LO, ctb_pkg::ASR_HI);
    viol_o[6] = bad(16'(cfg_i[2][ctb_pkg::NSS_LSB +: ctb_pkg::NSS_W]), ctb_pkg::NSS_LO, ctb_pkg::NSS_HI);
    viol_o[7] = bad(16'(cfg_i[2][ctb_pkg::SSL_LSB +: ctb_pkg::SSL_W]), ctb_pkg::SSL_LO, ctb_pkg::SSL_HI);
    viol_o[8] = bad(16'(cfg_i[3][ctb_pkg::NMS_LSB +: ctb_pkg::NMS_W]), ctb_pkg::NMS_LO, ctb_pkg::NMS_HI);
    viol_o[9] = bad(16'(cfg_i[3][ctb_pkg::MSL_LSB +: ctb_pkg::MSL_W]), ctb_pkg::MSL_LO, ctb_pkg::MSL_HI);
    viol_o[10] = bad(16'(cfg_i[4][ctb_pkg::DSI_LSB +: ctb_pkg::DSI_W]), ctb_pkg::DSI_LO, ctb_pkg::DSI_HI);
    viol_o[11] = bad(16'(cfg_i[4][ctb_pkg::MAPO_LSB +: ctb_pkg::MAPO_W]), ctb_pkg::MAPO_LO, ctb_pkg::MAPO_HI);
    viol_o[12] = bad(16'(cfg_i[4][ctb_pkg::APO_LSB +: ctb_pkg::APO_W]), ctb_pkg::APO_LO, ctb_pkg::APO_HI);
    viol_o[13] = bad(16'(cfg_i[5][ctb_pkg::MRC_LSB +: ctb_pkg::MRC_W]), ctb_pkg::MRC_LO, ctb_pkg::MRC_HI);
    viol_o[14] = bad(16'(cfg_i[5][ctb_pkg::MOC_LSB +: ctb_pkg::MOC_W]), ctb_pkg::MOC_LO, ctb_pkg::MOC_HI);
  end

endmodule // ctb_range_chk

/* File: hdl/ctb_dev_access.sv */
// Single register access on the device port, held until the device answers
`timescale 1ns/1ps
module ctb_dev_access (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // Request from the sequencer
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  output logic done_o,
  output logic [31:0] rdata_o,
  // Device port
  output logic dev_sel_o,
  output logic dev_we_o,
  output logic [7:0] dev_addr_o,
  output logic [31:0] dev_wdata_o,
  input wire logic [31:0] dev_rdata_i,
  input wire logic dev_ready_i
);

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dev_sel_o <= 1'b0;
      dev_we_o <= 1'b0;
      dev_addr_o <= 8'h00;
      dev_wdata_o <= 32'h00000000;
      done_o <= 1'b0;
      rdata_o <= 32'h00000000;
    end else begin
      done_o <= 1'b0;
      if (dev_sel_o && dev_ready_i) begin
        dev_sel_o <= 1'b0;
        dev_we_o <= 1'b0;
        done_o <= 1'b1;
        rdata_o <= dev_rdata_i;
      end else if (!dev_sel_o && req_i && !done_o) begin
        dev_sel_o <= 1'b1;
        dev_we_o <= we_i;
        dev_addr_o <= addr_i;
        dev_wdata_o <= wdata_i;
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  hold_dev_req_a: assert property (dev_sel_o && !dev_ready_i |=> dev_sel_o && $stable(dev_addr_o)
    && $stable(dev_we_o) && $stable(dev_wdata_o)) else $error("device request changed before answer");
  done_pulse_a: assert property (dev_sel_o && dev_ready_i |=> done_o && !dev_sel_o ##1 !done_o)
    else $error("access end not reported once");

endmodule // ctb_dev_access

/* File: verif/ctb_dev_model.sv */
// Behavioural model of the configured device behind the host controller
`timescale 1ns/1ps
module ctb_dev_model (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // Register port
  input wire logic dev_sel_i,
  input wire logic dev_we_i,
  input wire logic [7:0] dev_addr_i,
  input wire logic [31:0] dev_wdata_i,
  output logic [31:0] dev_rdata_o,
  output logic dev_ready_o,
  // Bench controls and views
  input wire logic [5:0] state_code_i,
  input wire logic [3:0] delay_i,
  output logic [ctb_pkg::NUM_CFG-1:0][31:0] cfg_o,
  output logic [7:0] wr_cnt_o
);
  localparam logic [31:0] CTRL_BITS = 32'h00000303;
  logic [3:0] cnt_q;
  logic cfg_ok;
  logic [2:0] idx;

  assign cfg_ok = (state_code_i == ctb_pkg::CODE_DEFAULT_CONFIG) || (state_code_i == ctb_pkg::CODE_CONFIG);
  assign idx = dev_addr_i[4:2];

  // ****************************************
  // Handshake and read data
  // ****************************************
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_q <= 4'h0;
      dev_ready_o <= 1'b0;
    end else if (!dev_sel_i || dev_ready_o) begin
      cnt_q <= 4'h0;
      dev_ready_o <= 1'b0;
    end else if (cnt_q == delay_i) begin
      dev_ready_o <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dev_rdata_o <= 32'h0;
    end else if (dev_sel_i && !dev_ready_o && cnt_q == delay_i) begin
      dev_rdata_o <= (dev_addr_i == ctb_pkg::DEV_STATUS) ? {26'h0, state_code_i} : cfg_o[idx];
    end else begin
      // Flips every cycle so stale data never passes for an answer
      dev_rdata_o <= ~dev_rdata_o;
    end
  end

  // ****************************************
  // Configuration storage
  // ****************************************
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_o <= '0;
      wr_cnt_o <= 8'h0;
    end else if (dev_sel_i && dev_ready_o && dev_we_i) begin
      wr_cnt_o <= wr_cnt_o + 8'h1;
      if (idx == ctb_pkg::EXT_IDX) begin
        // Control fields follow every write, magnitudes only in config states
        cfg_o[idx] <= (cfg_ok ? dev_wdata_i : ((cfg_o[idx] & ~CTRL_BITS) | (dev_wdata_i & CTRL_BITS)))
          & ctb_pkg::CFG_MASK[idx];
      end else if (cfg_ok && dev_addr_i < 8'h1c) begin
        cfg_o[idx] <= dev_wdata_i & ctb_pkg::CFG_MASK[idx];
      end
    end
  end
endmodule // ctb_dev_model

/* File: verif/test_ctb_host.sv */
// Self-checking bench of the timing configuration host controller
`timescale 1ns/1ps
module test_ctb_host;
  logic sys_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h0;
  logic [31:0] pwdata_i = 32'h0;
  logic nit_active_i = 1'b0;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic dev_sel_o;
  logic dev_we_o;
  logic [7:0] dev_addr_o;
  logic [31:0] dev_wdata_o;
  logic [31:0] dev_rdata_i;
  logic dev_ready_i;
  logic [5:0] state_code = 6'h0f;
  logic [3:0] delay = 4'h0;
  logic [ctb_pkg::NUM_CFG-1:0][31:0] dev_cfg;
  logic [7:0] wr_cnt;
  logic [31:0] sh [7] = '{default: 32'h0};
  logic [31:0] set_a [7] = '{32'h8f14c800, 32'h07830753, 32'h00020293, 32'h1f320002, 32'h00021f01,
    32'h00023ba2, 32'h07050302};
  logic [31:0] set_b [7] = '{32'h0e0000c8, 32'h00020000, 32'h03ff0004, 32'h0000003f, 32'h0000013f,
    32'h07830005, 32'h00000000};
  logic [31:0] rd;
  logic err;
  int errors = 0;
  int comparisons = 0;

  ctb_host ctb_host_inst (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .dev_sel_o(dev_sel_o), .dev_we_o(dev_we_o), .dev_addr_o(dev_addr_o),
    .dev_wdata_o(dev_wdata_o), .dev_rdata_i(dev_rdata_i), .dev_ready_i(dev_ready_i), .nit_active_i(nit_active_i));
  ctb_dev_model ctb_dev_model_inst (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .dev_sel_i(dev_sel_o),
    .dev_we_i(dev_we_o), .dev_addr_i(dev_addr_o), .dev_wdata_i(dev_wdata_o), .dev_rdata_o(dev_rdata_i),
    .dev_ready_o(dev_ready_i), .state_code_i(state_code), .delay_i(delay), .cfg_o(dev_cfg), .wr_cnt_o(wr_cnt));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic cmp32(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= we;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (n >= 20) errors++;
  endtask

  // Starts a command and polls status until busy drops; rd ends holding status
  task automatic run(input logic [31:0] cmd);
    int n;
    apb(1'b1, ctb_pkg::APB_CTRL, cmd);
    n = 0;
    do begin
      apb(1'b0, ctb_pkg::APB_STATUS, 32'h0);
      n++;
    end while (rd[ctb_pkg::ST_BUSY] !== 1'b0 && n < 60);
  endtask

  // Range flags of the shadow words: word, lsb, width, low, high per field
  function automatic logic [31:0] exp_viol();
    int t [15][5] = '{'{0, 24, 8, 14, 143}, '{0, 16, 5, 0, 20}, '{0, 8, 8, 0, 200}, '{0, 0, 8, 0, 200},
      '{1, 16, 11, 2, 1923}, '{1, 0, 11, 0, 1875}, '{2, 16, 10, 2, 1023}, '{2, 0, 10, 4, 659},
      '{3, 16, 13, 0, 7986}, '{3, 0, 6, 2, 63}, '{4, 16, 2, 0, 2}, '{4, 8, 5, 1, 31}, '{4, 0, 6, 1, 63},
      '{5, 16, 11, 2, 1923}, '{5, 0, 14, 5, 15266}};
    logic [31:0] v;
    int f;
    v = 32'h0;
    for (int k = 0; k < 15; k++) begin
      f = int'(sh[t[k][0]] >> t[k][1]) & ((1 << t[k][2]) - 1);
      v[k] = (f < t[k][3]) || (f > t[k][4]);
    end
    return v;
  endfunction

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      cmp32("reset word", 32'h0, rd);
    end
    apb(1'b0, ctb_pkg::APB_STATUS, 32'h0);
    cmp32("reset status", 32'h0, rd);
    apb(1'b0, ctb_pkg::APB_VIOL, 32'h0);
    cmp32("reset viol", exp_viol(), rd);
    $display("test reset done");
  endtask

  task automatic t_mask();
    for (int i = 0; i < 7; i++) begin
      sh[i] = 32'hffffffff;
      apb(1'b1, 8'(4 * i), sh[i]);
      apb(1'b0, 8'(4 * i), 32'h0);
      cmp32("masked word", ctb_pkg::CFG_MASK[i], rd);
    end
    apb(1'b0, ctb_pkg::APB_VIOL, 32'h0);
    cmp32("ones viol", exp_viol(), rd);
    apb(1'b1, 8'h28, 32'h1);
    cmp32("unmapped write err", 32'h1, {31'h0, err});
    apb(1'b0, 8'h30, 32'h0);
    cmp32("unmapped read err", 32'h1, {31'h0, err});
    cmp32("unmapped read data", 32'h0, rd);
    apb(1'b0, ctb_pkg::APB_CTRL, 32'h0);
    cmp32("ctrl read", 32'h0, rd);
    $display("test mask done");
  endtask

  task automatic t_load(input logic [5:0] code, input logic [3:0] dly, input logic [31:0] w [7]);
    logic [7:0] n0;
    state_code <= code;
    delay <= dly;
    // Stray bits in unassigned places must never reach the device
    for (int i = 0; i < 7; i++) sh[i] = w[i] | ~ctb_pkg::CFG_MASK[i];
    for (int i = 0; i < 7; i++) apb(1'b1, 8'(4 * i), sh[i]);
    apb(1'b0, ctb_pkg::APB_VIOL, 32'h0);
    cmp32("valid viol", exp_viol(), rd);
    n0 = wr_cnt;
    run(32'h1);
    cmp32("load status", {18'h0, code, 8'h02}, rd & 32'h3f1f);
    cmp32("load writes", {24'h0, n0 + 8'h7}, {24'h0, wr_cnt});
    for (int i = 0; i < 7; i++) cmp32("device word", w[i], dev_cfg[i]);
    $display("test load done");
  endtask

  task automatic t_state();
    logic [7:0] n0;
    state_code <= 6'h02;
    n0 = wr_cnt;
    run(32'h1);
    cmp32("refused status", 32'h0204, rd & 32'h3f1d);
    cmp32("refused writes", {24'h0, n0}, {24'h0, wr_cnt});
    for (int i = 0; i < 7; i++) cmp32("kept word", set_b[i], dev_cfg[i]);
    $display("test state done");
  endtask

  task automatic t_range();
    int bi [5] = '{0, 0, 5, 5, 2};
    logic [31:0] bw [5] = '{32'h0d0000c8, 32'h900000c8, 32'h07830004, 32'h07843ba3, 32'h00010004};
    logic [31:0] keep;
    logic [7:0] n0;
    state_code <= 6'h0f;
    for (int k = 0; k < 5; k++) begin
      keep = sh[bi[k]];
      sh[bi[k]] = bw[k];
      apb(1'b1, 8'(4 * bi[k]), bw[k]);
      apb(1'b0, ctb_pkg::APB_VIOL, 32'h0);
      cmp32("boundary viol", exp_viol(), rd);
      n0 = wr_cnt;
      run(32'h1);
      cmp32("range status", 32'h08, rd & 32'h1d);
      cmp32("range writes", {24'h0, n0}, {24'h0, wr_cnt});
      sh[bi[k]] = keep;
      apb(1'b1, 8'(4 * bi[k]), keep);
    end
    $display("test range done");
  endtask

  task automatic t_ext();
    logic [7:0] n0;
    state_code <= 6'h02;
    nit_active_i <= 1'b1;
    n0 = wr_cnt;
    run(32'h2);
    cmp32("nit status", 32'h10, rd & 32'h1d);
    cmp32("nit writes", {24'h0, n0}, {24'h0, wr_cnt});
    nit_active_i <= 1'b0;
    for (int k = 0; k < 5; k++) begin
      if (k == 4) state_code <= 6'h0f;
      sh[6] = {5'h0, 3'h3, 5'h0, 3'h4, 6'h0, 2'(k), 6'h0, 2'(3 - k)};
      apb(1'b1, 8'h18, sh[6]);
      run(32'h2);
      cmp32("ext status", 32'h02, rd & 32'h1f);
      // Outside config states only the control fields may move
      cmp32("ext word", (k == 4) ? sh[6] : (sh[6] & 32'h303), dev_cfg[6]);
    end
    $display("test ext done");
  endtask

  task automatic summarize();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  initial begin
    #200us;
    errors++;
    summarize();
  end

  initial begin
    repeat (3) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    t_reset();
    t_mask();
    t_load(6'h0f, 4'h0, set_a);
    t_load(6'h00, 4'h3, set_b);
    t_state();
    t_range();
    t_ext();
    summarize();
  end
endmodule // test_ctb_host
